// File: bfd_pkg.sv
// Purpose: shared types and constants for the branch and field datapath
// Assumes: 32-bit words, single core clock
// Notes:   field positions follow the single/double floating-point layouts
package bfd_pkg;

    localparam int          WORD_W        = 32;
    localparam logic [31:0] LINK_OFFSET   = 32'h0000_0008;
    localparam logic [31:0] DEC_STEP      = 32'h0000_0001;
    localparam logic [31:0] WORD_RESET    = 32'h0000_0000;
    localparam logic [1:0]  PTR_RESET     = 2'h0;
    localparam int          BOOL_BIT      = 31;
    localparam int          SP_SIGN_POS   = 31;
    localparam int          SP_EXP_LSB    = 23;
    localparam int          SP_EXP_W      = 8;
    localparam int          SP_FRAC_W     = 23;
    localparam logic [7:0]  SP_BIAS       = 8'h7f;
    localparam int          DP_EXP_LSB    = 20;
    localparam int          DP_EXP_W      = 11;
    localparam int          DP_FRAC_HI_W  = 20;
    localparam logic [10:0] DP_BIAS       = 11'h3ff;

    typedef enum logic [4:0] {
        BFD_OP_NONE,
        BFD_OP_CALL,
        BFD_OP_SUBROUTINE_LINK_INDIRECT,
        BFD_OP_BRANCH_DIRECT,
        BFD_OP_BRANCH_INDIRECT,
        BFD_OP_BRANCH_ON_TRUE,
        BFD_OP_BRANCH_ON_TRUE_INDIRECT,
        BFD_OP_BRANCH_ON_FALSE,
        BFD_OP_BRANCH_ON_FALSE_INDIRECT,
        BFD_OP_LOOP_DECREMENT_BRANCH,
        BFD_OP_LEADING_ZERO_COUNT,
        BFD_OP_BYTE_EXTRACT,
        BFD_OP_BYTE_INSERT,
        BFD_OP_BYTE_MATCH_COMPARE,
        BFD_OP_HALFWORD_EXTRACT,
        BFD_OP_HALFWORD_EXTRACT_SIGNED,
        BFD_OP_HALFWORD_INSERT,
        BFD_OP_COMPARE_BOOL,
        BFD_OP_LOAD,
        BFD_OP_STORE,
        BFD_OP_FP_UNPACK
    } bfd_op_t;

    typedef enum logic [1:0] {
        BFD_W_BYTE,
        BFD_W_HALF,
        BFD_W_WORD
    } bfd_width_t;

    // one issued operation with its operands
    typedef struct packed {
        logic        valid;
        bfd_op_t     op;
        logic [31:0] first_source;
        logic [31:0] second_source;
        logic [31:0] result_register;
        logic [31:0] target;
        logic [31:0] pc;
        logic        use_imm_byte;
        logic [7:0]  imm_byte;
        logic        cmp_true;
        bfd_width_t  width;
        logic        sign_select_bit;
        logic [31:0] address;
        logic [31:0] load_data;
        logic        fp_double;
    } bfd_req_t;

    // results written back and offered to the fetch unit
    typedef struct packed {
        logic        wr_result;
        logic [31:0] result_value;
        logic        wr_first;
        logic [31:0] first_value;
        logic        redirect;
        logic [31:0] redirect_pc;
        logic        store_valid;
        logic [31:0] store_data;
        logic        narrow_fault;
    } bfd_rsp_t;

    // unpacked floating-point fields
    typedef struct packed {
        logic        sign;
        logic [10:0] bexp;
        logic [51:0] frac;
        logic        implied_one;
        logic [12:0] unbiased;
    } bfd_fp_t;

endpackage : bfd_pkg

// File: bfd_fp_fields.sv
// Purpose: unpack single or double floating-point fields
// Assumes: double operand arrives as even word then odd word
// Notes:   purely combinational; the caller registers the result
`timescale 1ns/10ps
module bfd_fp_fields (
    // operand words
    input  wire logic [31:0]      word_even,
    input  wire logic [31:0]      word_odd,
    input  wire logic             is_double,
    // unpacked fields
    output bfd_pkg::bfd_fp_t      fields
);
    import bfd_pkg::*;

    always_comb begin
        fields = '0;
        if (is_double) begin
            fields.sign     = word_even[SP_SIGN_POS];
            fields.bexp     = word_even[DP_EXP_LSB +: DP_EXP_W];
            fields.frac     = {word_even[DP_FRAC_HI_W-1:0], word_odd};
            fields.unbiased = 13'({2'b00, fields.bexp}) - 13'({2'b00, DP_BIAS});
        end else begin
            fields.sign     = word_even[SP_SIGN_POS];
            fields.bexp     = {3'h0, word_even[SP_EXP_LSB +: SP_EXP_W]};
            fields.frac     = {word_even[SP_FRAC_W-1:0], 29'h0};
            fields.unbiased = 13'({5'h00, fields.bexp[7:0]}) - 13'({5'h00, SP_BIAS});
        end
        // zero exponent means no leading one
        fields.implied_one = |fields.bexp;
    end

endmodule : bfd_fp_fields

// File: bfd_datapath.sv
// Purpose: branch, loop, bit-field, narrow-store and fp-field datapath
// Assumes: one operation per cycle, results one cycle after issue
// Notes:   delay slot is honoured by deferring the redirect one issue
//
// Summary of operation
// - calls link aligned pc plus eight
// - branches run one delay slot first
// - true branches need first source true
// - false branches need first source false
// - loop always decrements, branches when false
// - boolean is the word's top bit
// - compares clear all but top bit
// - count zeros from the top end
// - byte extract into low byte
// - byte insert keeps other bytes
// - byte match true on any equal byte
// - byte numbering follows byte order flag
// - halfword numbering follows same flag
// - narrow loads only when enabled
// - byte store replicated to four lanes
// - halfword store replicated to both lanes
// - halfword extract into low half
// - signed extract fills top sixteen bits
// - halfword insert keeps other half
// - single precision bias 127 fields
// - double precision bias 1023 fields
// - sign select extends narrow loads
// - pointer set loads byte pointer
`timescale 1ns/10ps
module bfd_datapath (
    // clock and reset
    input  wire logic              clock,
    input  wire logic              rst_n,
    // configuration bits
    input  wire logic              byte_order_flag,
    input  wire logic              narrow_access_enable,
    // issued operation
    input  bfd_pkg::bfd_req_t      req,
    // results
    output bfd_pkg::bfd_rsp_t      rsp,
    output logic [1:0]             byte_pointer,
    output bfd_pkg::bfd_fp_t       fp_fields
);
    import bfd_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic is_true(input logic [31:0] w);
        return w[BOOL_BIT];
    endfunction : is_true

    // lane of a byte for a given pointer and order
    function automatic logic [1:0] byte_lane(input logic [1:0] ptr, input logic order);
        return order ? ~ptr : ptr;
    endfunction : byte_lane

    function automatic logic half_lane(input logic ptr1, input logic order);
        return order ? ~ptr1 : ptr1;
    endfunction : half_lane

    function automatic logic [5:0] count_zeros(input logic [31:0] w);
        logic [5:0] n;
        logic       done;
        n    = 6'h00;
        done = 1'b0;
        for (int i = 31; i >= 0; i--) begin
            if (!done && !w[i]) begin
                n = n + 6'h01;
            end else begin
                done = 1'b1;
            end
        end
        return n;
    endfunction : count_zeros

    function automatic logic [7:0] pick_byte(input logic [31:0] w, input logic [1:0] lane);
        return w[8*lane +: 8];
    endfunction : pick_byte

    function automatic logic [15:0] pick_half(input logic [31:0] w, input logic lane);
        return w[16*lane +: 16];
    endfunction : pick_half

    ////////////////////////////////////////////////////////////////////////
    // combinational result

    logic [1:0]  ptr_reg;
    logic [1:0]  ptr_next;
    logic        pend_reg;
    logic [31:0] pend_pc_reg;
    logic        take;
    logic [31:0] tgt;
    bfd_rsp_t    rsp_next;
    bfd_fp_t     fp_next;
    logic [1:0]  blane;
    logic        hlane;
    logic [7:0]  bval;
    logic [15:0] hval;
    logic [31:0] ins_word;
    logic        any_eq;
    logic [31:0] link_pc;

    assign blane   = byte_lane(ptr_reg, byte_order_flag);
    assign hlane   = half_lane(ptr_reg[1], byte_order_flag);
    assign link_pc = {req.pc[31:2], 2'b00} + LINK_OFFSET;

    always_comb begin
        take = 1'b0;
        tgt  = req.target;
        unique case (req.op)
            BFD_OP_CALL, BFD_OP_BRANCH_DIRECT:
                take = 1'b1;
            BFD_OP_SUBROUTINE_LINK_INDIRECT, BFD_OP_BRANCH_INDIRECT: begin
                take = 1'b1;
                tgt  = req.second_source;
            end
            BFD_OP_BRANCH_ON_TRUE:
                take = is_true(req.first_source);
            BFD_OP_BRANCH_ON_TRUE_INDIRECT: begin
                take = is_true(req.first_source);
                tgt  = req.second_source;
            end
            BFD_OP_BRANCH_ON_FALSE:
                take = !is_true(req.first_source);
            BFD_OP_BRANCH_ON_FALSE_INDIRECT: begin
                take = !is_true(req.first_source);
                tgt  = req.second_source;
            end
            BFD_OP_LOOP_DECREMENT_BRANCH:
                take = !is_true(req.first_source);
            default:
                take = 1'b0;
        endcase
        take = take & req.valid;
    end

    always_comb begin
        ins_word = req.result_register;
        bval     = req.use_imm_byte ? req.imm_byte : req.second_source[7:0];
        ins_word[8*blane +: 8] = bval;
        any_eq = 1'b0;
        for (int i = 0; i < 4; i++) begin
            if (req.first_source[8*i +: 8] == req.second_source[8*i +: 8]) begin
                any_eq = 1'b1;
            end
        end
        hval = pick_half(req.second_source, hlane);
    end

    always_comb begin
        rsp_next = '0;
        ptr_next = ptr_reg;
        unique case (req.op)
            BFD_OP_CALL, BFD_OP_SUBROUTINE_LINK_INDIRECT: begin
                rsp_next.wr_result    = 1'b1;
                rsp_next.result_value = link_pc;
            end
            BFD_OP_LOOP_DECREMENT_BRANCH: begin
                rsp_next.wr_first    = 1'b1;
                rsp_next.first_value = req.first_source - DEC_STEP;
            end
            BFD_OP_LEADING_ZERO_COUNT: begin
                rsp_next.wr_result    = 1'b1;
                rsp_next.result_value = {26'h0, count_zeros(req.second_source)};
            end
            BFD_OP_BYTE_EXTRACT: begin
                rsp_next.wr_result    = 1'b1;
                rsp_next.result_value = {req.result_register[31:8],
                                         pick_byte(req.second_source, blane)};
            end
            BFD_OP_BYTE_INSERT: begin
                rsp_next.wr_result    = 1'b1;
                rsp_next.result_value = ins_word;
            end
            BFD_OP_BYTE_MATCH_COMPARE: begin
                rsp_next.wr_result    = 1'b1;
                rsp_next.result_value = {any_eq, 31'h0};
            end
            BFD_OP_COMPARE_BOOL: begin
                rsp_next.wr_result    = 1'b1;
                rsp_next.result_value = {req.cmp_true, 31'h0};
            end
            BFD_OP_HALFWORD_EXTRACT: begin
                rsp_next.wr_result    = 1'b1;
                rsp_next.result_value = {req.result_register[31:16], hval};
            end
            BFD_OP_HALFWORD_EXTRACT_SIGNED: begin
                rsp_next.wr_result    = 1'b1;
                rsp_next.result_value = {{16{hval[15]}}, hval};
            end
            BFD_OP_HALFWORD_INSERT: begin
                rsp_next.wr_result    = 1'b1;
                rsp_next.result_value = req.result_register;
                rsp_next.result_value[16*hlane +: 16] = req.second_source[15:0];
            end
            BFD_OP_LOAD: begin
                rsp_next.wr_result = 1'b1;
                if (req.width != BFD_W_WORD && narrow_access_enable) begin
                    if (req.width == BFD_W_BYTE) begin
                        rsp_next.result_value = {{24{req.sign_select_bit & req.load_data[7]}},
                                                 req.load_data[7:0]};
                    end else begin
                        rsp_next.result_value = {{16{req.sign_select_bit & req.load_data[15]}},
                                                 req.load_data[15:0]};
                    end
                end else if (req.width != BFD_W_WORD) begin
                    rsp_next.wr_result    = 1'b0;
                    rsp_next.narrow_fault = 1'b1;
                end else begin
                    rsp_next.result_value = req.load_data;
                end
            end
            BFD_OP_STORE: begin
                rsp_next.store_valid = 1'b1;
                rsp_next.store_data  = req.first_source;
                if (req.width == BFD_W_BYTE && narrow_access_enable) begin
                    rsp_next.store_data = {4{req.first_source[7:0]}};
                end else if (req.width == BFD_W_HALF && narrow_access_enable) begin
                    rsp_next.store_data = {2{req.first_source[15:0]}};
                end else if (req.width != BFD_W_WORD) begin
                    rsp_next.store_valid  = 1'b0;
                    rsp_next.narrow_fault = 1'b1;
                end
            end
            default: begin
                rsp_next = '0;
            end
        endcase
        if (!req.valid) begin
            rsp_next = '0;
        end
        if (req.valid && (req.op == BFD_OP_LOAD || req.op == BFD_OP_STORE) &&
            !narrow_access_enable && req.sign_select_bit) begin
            ptr_next = req.address[1:0];
        end else if (req.valid && (req.op == BFD_OP_LOAD || req.op == BFD_OP_STORE) &&
                     narrow_access_enable && req.sign_select_bit) begin
            ptr_next = {2{~byte_order_flag}};
        end
        rsp_next.redirect    = pend_reg & req.valid;
        rsp_next.redirect_pc = pend_pc_reg;
    end

    ////////////////////////////////////////////////////////////////////////
    // floating-point fields

    bfd_fp_fields u_fp (
        .word_even (req.first_source),
        .word_odd  (req.second_source),
        .is_double (req.fp_double),
        .fields    (fp_next)
    );

    ////////////////////////////////////////////////////////////////////////
    // state

    // branch held over its delay slot
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pend_reg    <= 1'b0;
            pend_pc_reg <= WORD_RESET;
        end else if (req.valid) begin
            pend_reg    <= take;
            pend_pc_reg <= tgt;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ptr_reg <= PTR_RESET;
        end else begin
            ptr_reg <= ptr_next;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rsp          <= '0;
            byte_pointer <= PTR_RESET;
            fp_fields    <= '0;
        end else begin
            rsp          <= rsp_next;
            byte_pointer <= ptr_next;
            fp_fields    <= (req.valid && req.op == BFD_OP_FP_UNPACK) ? fp_next : fp_fields;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks

    sequence s_branch_taken;
        req.valid && take;
    endsequence

    sequence s_slot_issued;
        req.valid && !take;
    endsequence

    AST_CALL_LINK: assert property (@(posedge clock) disable iff (!rst_n)
        req.valid && req.op == BFD_OP_CALL |=> rsp.wr_result &&
        rsp.result_value == {$past(req.pc[31:2]), 2'b00} + LINK_OFFSET)
        else $error("call link value wrong");

    AST_DELAY_SLOT: assert property (@(posedge clock) disable iff (!rst_n)
        s_branch_taken ##1 s_slot_issued |=> rsp.redirect)
        else $error("redirect missing after delay slot");

    AST_NO_EARLY: assert property (@(posedge clock) disable iff (!rst_n)
        s_branch_taken |=> !rsp.redirect || $past(pend_reg))
        else $error("redirect before delay slot");

    AST_TRUE_GATE: assert property (@(posedge clock) disable iff (!rst_n)
        req.valid && req.op == BFD_OP_BRANCH_ON_TRUE && !req.first_source[31] |-> !take)
        else $error("true branch on false");

    AST_FALSE_GATE: assert property (@(posedge clock) disable iff (!rst_n)
        req.valid && req.op == BFD_OP_BRANCH_ON_FALSE |-> take == !req.first_source[31])
        else $error("false branch condition wrong");

    AST_LOOP_DEC: assert property (@(posedge clock) disable iff (!rst_n)
        req.valid && req.op == BFD_OP_LOOP_DECREMENT_BRANCH |=>
        rsp.wr_first && rsp.first_value == $past(req.first_source) - DEC_STEP)
        else $error("loop decrement wrong");

    AST_BOOL_CLEAR: assert property (@(posedge clock) disable iff (!rst_n)
        req.valid && (req.op == BFD_OP_BYTE_MATCH_COMPARE || req.op == BFD_OP_COMPARE_BOOL)
        |=> rsp.result_value[30:0] == 31'h0)
        else $error("compare low bits not cleared");

    AST_BYTE_STORE: assert property (@(posedge clock) disable iff (!rst_n)
        req.valid && req.op == BFD_OP_STORE && req.width == BFD_W_BYTE && narrow_access_enable
        |=> rsp.store_data == {4{$past(req.first_source[7:0])}})
        else $error("byte store not replicated");

    AST_HALF_STORE: assert property (@(posedge clock) disable iff (!rst_n)
        req.valid && req.op == BFD_OP_STORE && req.width == BFD_W_HALF && narrow_access_enable
        |=> rsp.store_data == {2{$past(req.first_source[15:0])}})
        else $error("half store not replicated");

    AST_SIGNED_HALF: assert property (@(posedge clock) disable iff (!rst_n)
        req.valid && req.op == BFD_OP_HALFWORD_EXTRACT_SIGNED |=>
        rsp.result_value[31:16] == {16{rsp.result_value[15]}})
        else $error("signed half fill wrong");

    AST_PTR_SET: assert property (@(posedge clock) disable iff (!rst_n)
        req.valid && req.op == BFD_OP_LOAD && !narrow_access_enable && req.sign_select_bit
        |=> byte_pointer == $past(req.address[1:0]))
        else $error("byte pointer not set");

endmodule : bfd_datapath

// File: bfd_datapath_tb_top.sv
// Purpose: self-checking bench for the branch and field datapath
// Assumes: results one cycle after issue, redirect after the slot
// Notes:   inputs change on the falling edge only
`timescale 1ns/10ps
module bfd_datapath_tb_top;
import bfd_pkg::*;
logic        clock;
logic        rst_n;
logic        byte_order_flag;
logic        narrow_access_enable;
bfd_req_t    req;
bfd_rsp_t    rsp;
logic [1:0]  byte_pointer;
bfd_fp_t     fp_fields;
int          n_errors;
int          n_compared;
////////////////////////////////////////////////////////////////////////////////
bfd_datapath dut (.clock(clock), .rst_n(rst_n), .byte_order_flag(byte_order_flag),
    .narrow_access_enable(narrow_access_enable), .req(req), .rsp(rsp),
    .byte_pointer(byte_pointer), .fp_fields(fp_fields));
always #10 clock = ~clock;
////////////////////////////////////////////////////////////////////////////////
task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
        n_errors++;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
endtask : chk
// rsp seen at the next falling edge belongs to the previous issue
task automatic go(input bfd_req_t r);
    @(negedge clock);
    req = r;
endtask : go
function automatic bfd_req_t mk(input bfd_op_t op, input logic [31:0] a, b, d);
    mk = '0;
    mk.valid = 1'b1;
    mk.op = op;
    mk.first_source = a;
    mk.second_source = b;
    mk.result_register = d;
    mk.target = 32'h0000_4000;
endfunction : mk
task automatic tally_and_finish;
    $display("compared=%0d errors=%0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
        $display("Run complete: PASS");
    else
        $display("Run complete: FAIL");
    $finish;
endtask : tally_and_finish
////////////////////////////////////////////////////////////////////////////////
task automatic t_branch;
    bfd_op_t  ops [8];
    bfd_req_t r;
    logic     tk;
    ops = '{BFD_OP_CALL, BFD_OP_SUBROUTINE_LINK_INDIRECT, BFD_OP_BRANCH_DIRECT,
        BFD_OP_BRANCH_INDIRECT, BFD_OP_BRANCH_ON_TRUE, BFD_OP_BRANCH_ON_TRUE_INDIRECT,
        BFD_OP_BRANCH_ON_FALSE, BFD_OP_BRANCH_ON_FALSE_INDIRECT};
    for (int i = 0; i < 16; i++) begin
        // negative words must read as true
        r = mk(ops[i/2], {i[0], 31'h7fff_fff0}, 32'h0000_2000 + 32'(i), 32'h0);
        r.pc = 32'h0000_1003 + 32'(i * 4);
        tk = (i < 8) || ((i < 12) == r.first_source[31]);
        go(r);
        go(mk(BFD_OP_BYTE_MATCH_COMPARE, 32'h0102_0304, 32'h0506_0708, 32'h0));
        chk(32'(rsp.redirect), 32'h0); // not before slot
        if (i < 4) chk(rsp.result_value, {r.pc[31:2], 2'b00} + LINK_OFFSET); // link
        go('0);
        chk(32'(rsp.redirect), 32'(tk)); // condition
        chk(32'(rsp.wr_result), 32'h1); // slot ran
        chk(rsp.result_value, 32'h0); // no byte equal
        if (tk) chk(rsp.redirect_pc, i[1] ? r.second_source : r.target); // target
    end
endtask : t_branch
task automatic t_loop;
    bfd_req_t r;
    for (int j = 0; j < 2; j++) begin
        r = mk(BFD_OP_LOOP_DECREMENT_BRANCH, j ? 32'h8000_0000 : 32'h0, 32'h0, 32'h0);
        go(r);
        go(mk(BFD_OP_BYTE_MATCH_COMPARE, 32'h0, 32'h0, 32'h0));
        chk(32'(rsp.wr_first), 32'h1); // dec written
        chk(rsp.first_value, r.first_source - 32'h1); // dec
        go('0);
        chk(32'(rsp.redirect), 32'(j == 0)); // branch on false
        chk(rsp.result_value, 32'h8000_0000); // slot ran
    end
endtask : t_loop
task automatic t_fields;
    bfd_req_t    r;
    logic [31:0] d;
    logic [31:0] e;
    logic [15:0] hx;
    int          b;
    int          h;
    logic [31:0] zv [4];
    d = 32'haabb_ccdd;
    for (int k = 0; k < 8; k++) begin
        b = k[2] ? 24 - 8 * k[1:0] : 8 * k[1:0];
        h = (k[1] ^ k[2]) ? 16 : 0;
        hx = 16'(32'h8123_4567 >> h);
        r = mk(BFD_OP_LOAD, 32'h0, 32'h0, 32'h0);
        r.sign_select_bit = 1'b1;
        r.address = 32'(k[1:0]);
        r.width = BFD_W_WORD;
        go(r);
        byte_order_flag = k[2];
        go(mk(BFD_OP_BYTE_EXTRACT, 32'h0, 32'h1122_3344, d));
        chk(32'(byte_pointer), 32'(k[1:0])); // pointer set
        r = mk(BFD_OP_BYTE_INSERT, 32'h0, 32'h0000_005a, d);
        go(r);
        chk(rsp.result_value, {d[31:8], 8'(32'h1122_3344 >> b)}); // extract
        r.use_imm_byte = 1'b1;
        r.imm_byte = 8'h77;
        go(r);
        e = d;
        e[b+:8] = 8'h5a;
        chk(rsp.result_value, e); // insert
        go(mk(BFD_OP_HALFWORD_EXTRACT, 32'h0, 32'h8123_4567, d));
        e[b+:8] = 8'h77;
        chk(rsp.result_value, e); // immediate
        go(mk(BFD_OP_HALFWORD_EXTRACT_SIGNED, 32'h0, 32'h8123_4567, d));
        chk(rsp.result_value, {d[31:16], hx}); // half extract
        go(mk(BFD_OP_HALFWORD_INSERT, 32'h0, 32'h1234_beef, d));
        chk(rsp.result_value, {{16{hx[15]}}, hx}); // sign fill
        go('0);
        e = d;
        e[h+:16] = 16'hbeef;
        chk(rsp.result_value, e); // half insert
    end
    go(mk(BFD_OP_BYTE_MATCH_COMPARE, 32'h1122_3344, 32'hff22_ff00, 32'h0));
    r = mk(BFD_OP_COMPARE_BOOL, 32'h0, 32'h0, 32'hffff_ffff);
    r.cmp_true = 1'b1;
    go(r);
    chk(rsp.result_value, 32'h8000_0000); // one byte equal
    go('0);
    chk(rsp.result_value, 32'h8000_0000); // low bits cleared
    zv = '{32'h0, 32'h1, 32'h8000_0000, 32'h0001_0000};
    for (int j = 0; j < 4; j++) begin
        go(mk(BFD_OP_LEADING_ZERO_COUNT, 32'h0, zv[j], 32'h0));
        go('0);
        chk(rsp.result_value, 32'(32 - $clog2(zv[j] + 64'h1))); // zero count
    end
endtask : t_fields
task automatic t_narrow;
    bfd_req_t r;
    narrow_access_enable = 1'b1;
    for (int j = 0; j < 4; j++) begin
        r = mk(BFD_OP_LOAD, 32'h0, 32'h0, 32'h0);
        r.width = j[1] ? BFD_W_HALF : BFD_W_BYTE;
        r.sign_select_bit = j[0];
        r.load_data = 32'h8080_8080;
        go(r);
        r = mk(BFD_OP_STORE, 32'h1234_56ab, 32'h1234_56ab, 32'h0);
        r.width = j[1] ? BFD_W_HALF : BFD_W_BYTE;
        go(r);
        chk(rsp.result_value, j[0] ? (j[1] ? 32'hffff_8080 : 32'hffff_ff80)
            : (j[1] ? 32'h0000_8080 : 32'h0000_0080)); // extension
        go('0);
        chk(rsp.store_data, j[1] ? 32'h56ab_56ab : 32'habab_abab); // lanes
    end
    // a narrow store while disabled must be refused, not sent
    narrow_access_enable = 1'b0;
    go(r);
    go('0);
    chk(32'({rsp.store_valid, rsp.narrow_fault}), 32'h1); // refused
endtask : t_narrow
task automatic t_fp;
    bfd_req_t r;
    go(mk(BFD_OP_FP_UNPACK, 32'hbf00_0000, 32'h0, 32'h0));
    r = mk(BFD_OP_FP_UNPACK, 32'hc009_0000, 32'h1234_5678, 32'h0);
    r.fp_double = 1'b1;
    go(r); // even word first
    chk(32'({fp_fields.implied_one, fp_fields.sign}), 32'h3);
    chk(32'(fp_fields.bexp), 32'h0000_007e);
    chk(32'(fp_fields.unbiased), 32'h0000_1fff);
    go('0);
    chk(32'({fp_fields.implied_one, fp_fields.sign}), 32'h3);
    chk(32'(fp_fields.bexp), 32'h0000_0400);
    chk(32'(fp_fields.unbiased), 32'h0000_0001);
    chk({12'h0, fp_fields.frac[51:32]}, 32'h0009_0000); // high fraction
    chk(fp_fields.frac[31:0], 32'h1234_5678); // odd word
endtask : t_fp
////////////////////////////////////////////////////////////////////////////////
initial begin
    clock = 1'b0;
    rst_n = 1'b0;
    req = '0;
    byte_order_flag = 1'b0;
    narrow_access_enable = 1'b0;
    n_errors = 0;
    n_compared = 0;
    repeat (2) @(posedge clock);
    @(negedge clock);
    chk(32'({rsp.redirect, byte_pointer}), 32'h0);
    rst_n = 1'b1;
    t_branch;
    t_loop;
    t_fields;
    t_narrow;
    t_fp;
    tally_and_finish;
end
// the whole run needs about 150 cycles; this leaves ample margin
initial begin
    repeat (5000) @(posedge clock);
    n_errors++;
    tally_and_finish;
end
endmodule : bfd_datapath_tb_top
